// ### htq_crc_byte.sv
// One byte step of the Ethernet frame check sequence, reflected form
`timescale 1ns/1ns
module htq_crc_byte (
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [31:0] crc_out
);
   // ==========================================================
   // Bitwise unrolled over eight steps
   always_comb begin
      logic [31:0] c;
      c = crc_in;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ data_in[i]) begin
            c = (c >> 1) ^ 32'hedb88320;
         end else begin
            c = c >> 1;
         end
      end
      crc_out = c;
   end
endmodule

// ### htq_mac_sink.sv
// Port-3 MAC stand-in that drains transmit bytes, promptly or with stalls
`timescale 1ns/1ns
module htq_mac_sink (
   input wire logic clk_in,
   input wire logic stall_en_in,
   output logic mac_ready_out = 1'b0
);
   logic [15:0] pat_q = 16'hace1;

   // ==========================================================
   // Pseudo-random stalls stress the hold-until-taken path
   always @(negedge clk_in) begin
      pat_q <= {pat_q[14:0], pat_q[15] ^ pat_q[13] ^ pat_q[12] ^ pat_q[10]};
      mac_ready_out <= !stall_en_in || pat_q[0];
   end
endmodule

// ### htq_pkg.sv
// Constants, register map and types for the host transmit queue frame path
package htq_pkg;
   // ==========================================================
   // Register offsets (byte addresses on the host bus)
   localparam logic [8:0] HTQ_OFS_TX_CONTROL = 9'h170;
   localparam logic [8:0] HTQ_OFS_TX_FRAME_STATUS = 9'h172;
   localparam logic [8:0] HTQ_OFS_TX_FREE_MEMORY_INFO = 9'h178;
   localparam logic [8:0] HTQ_OFS_TX_QUEUE_COMMAND = 9'h180;
   localparam logic [8:0] HTQ_OFS_RX_QUEUE_COMMAND = 9'h182;
   localparam logic [8:0] HTQ_OFS_TX_DATA_POINTER = 9'h184;
   localparam logic [8:0] HTQ_OFS_INTERRUPT_ENABLE = 9'h190;
   localparam logic [8:0] HTQ_OFS_INTERRUPT_STATUS = 9'h192;
   localparam logic [8:0] HTQ_OFS_TX_SPACE_NEEDED = 9'h19e;
   localparam logic [8:0] HTQ_OFS_TX_QUEUE_DATA = 9'h1c0;
   localparam int HTQ_ADDR_W = 9;

   // ==========================================================
   // Field positions
   localparam int HTQ_TXC_ENABLE = 0;
   localparam int HTQ_TXC_CRC = 1;
   localparam int HTQ_TXC_PAD = 2;
   localparam int HTQ_TXC_FLOW = 3;
   localparam int HTQ_TXC_CSUM_LO = 5;
   localparam int HTQ_TQC_ENQUEUE = 0;
   localparam int HTQ_TQC_SPACE_REQ = 1;
   localparam int HTQ_RQC_ACCESS = 3;
   localparam int HTQ_PTR_AUTO_INC = 14;
   localparam int HTQ_IRQ_TX_DONE = 14;
   localparam int HTQ_IRQ_TX_SPACE = 6;
   localparam int HTQ_CW_IRQ_ON_COMPLETION = 15;
   localparam int HTQ_TFS_BUSY = 8;

   // ==========================================================
   // Reset values
   localparam logic [15:0] HTQ_RST_TX_CONTROL = 16'h0000;
   localparam logic [15:0] HTQ_RST_REG = 16'h0000;
   localparam logic [31:0] HTQ_CRC_INIT = 32'hffffffff;

   // ==========================================================
   // Queue geometry
   localparam int HTQ_MEM_WORDS = 3072;
   localparam int HTQ_IDX_W = 12;
   localparam logic [12:0] HTQ_MEM_BYTES = 13'h1800;
   localparam logic [11:0] HTQ_MIN_FRAME = 12'h03c;
   localparam logic [11:0] HTQ_HDR_WORDS = 12'h002;
   localparam logic [15:0] HTQ_CLEAR_ALL = 16'hffff;

   typedef enum logic [1:0] {
      HTQ_IDLE = 2'b00,
      HTQ_DATA = 2'b01,
      HTQ_FCS = 2'b10
   } htq_tx_state_e;
endpackage

// ### htq_tx_path.sv
// Host transmit queue: register file, queue memory and MAC-side drain
`timescale 1ns/1ns

// Functional notes
// R1: Frame holds control word, byte count, data.
// R2: Append hardware CRC when CRC enable set.
// R3: Queue frames back to back while memory lasts; code ignores an enqueue while the enqueue bit is still set.
// R4: Status reports frame now on MAC side.
// R5: Big-endian swaps header word bytes.
// R6: Host keeps frame data within 2000 bytes.
// R7: Host writes one aligned control word per frame.
// R8: Completion bit raises transmit-done interrupt.
// R9: Frame identifier copied into status register.
// R10: Host gives correct nonzero 11-bit count.
// R11: All bytes from host, passed untouched.
// R12: Control bits: flow, pad, CRC, enable.
// R13: Control bits 8:5 enable checksum offload.
// R14: Free memory field reports bytes left.
// R15: Manual enqueue bit, self-clears when sent.
// R16: Host waits for enqueue bit clear.
// R17: Space request raises status bit 6.
// R18: Host programs space needed in dwords.
// R19: Queue command bit 3 opens memory access.
// R20: Pointer bit 14 enables auto-increment.
// R21: Enable bits 14 and 6 gate interrupts.
// R22: Writing all ones clears all status.
// R23: Host pads data to dword boundary.
// R24: Free space shrinks on write, returns after send.
module htq_tx_path
   import htq_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [htq_pkg::HTQ_ADDR_W-1:0] host_addr_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [1:0] host_be_in,
   input wire logic [15:0] host_wdata_in,
   input wire logic host_big_endian_in,
   input wire logic mac_ready_in,
   output logic [15:0] host_rdata_out,
   output logic host_irq_out,
   output logic [7:0] mac_data_out,
   output logic mac_valid_out,
   output logic mac_last_out,
   output logic mac_flow_ctrl_en_out,
   output logic [3:0] mac_csum_en_out
);
   import htq_pkg::*;

   typedef struct packed {
      logic wr_s1, wr_s2, wr_s3;
      logic rd_s1, rd_s2, rd_s3;
      logic big_s1, big_s2;
      logic [HTQ_ADDR_W-1:0] addr_s1, addr_s2;
      logic [1:0] be_s1, be_s2;
      logic [15:0] wd_s1, wd_s2;
      logic [15:0] tx_control;
      logic [15:0] tx_frame_status;
      logic [1:0] tx_queue_command;
      logic [15:0] rx_queue_command;
      logic [15:0] tx_data_pointer;
      logic [15:0] interrupt_enable;
      logic [15:0] interrupt_status;
      logic [15:0] tx_space_needed;
      logic [HTQ_IDX_W-1:0] wr_base;
      logic [HTQ_IDX_W-1:0] rd_base;
      logic [12:0] used_words;
      logic [HTQ_IDX_W-1:0] pending;
      htq_tx_state_e st;
      logic [15:0] ctrl;
      logic [10:0] cnt;
      logic [11:0] idx;
      logic [31:0] crc;
      logic [7:0] mac_data;
      logic mac_valid;
      logic mac_last;
      logic [15:0] rdata;
      logic irq;
      logic [HTQ_MEM_WORDS-1:0][15:0] mem;
   } htq_state_s;

   htq_state_s s_q, s_d;
   logic [7:0] next_byte;
   logic [31:0] crc_next;

   // ==========================================================
   // Helpers
   function automatic logic [HTQ_IDX_W-1:0] wrap_add(input logic [HTQ_IDX_W-1:0] a,
                                                     input logic [HTQ_IDX_W-1:0] b);
      logic [HTQ_IDX_W:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      if (sum >= (HTQ_IDX_W+1)'(HTQ_MEM_WORDS)) begin
         sum = sum - (HTQ_IDX_W+1)'(HTQ_MEM_WORDS);
      end
      return sum[HTQ_IDX_W-1:0];
   endfunction

   function automatic logic [15:0] hdr_word(input logic [15:0] w, input logic big);
      return big ? {w[7:0], w[15:8]} : w; // R5
   endfunction

   function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be);
      return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // Words a frame occupies: header plus data rounded up to dwords
   function automatic logic [HTQ_IDX_W-1:0] frame_words(input logic [10:0] c);
      logic [11:0] dw;
      dw = ({1'b0, c} + 12'h003) >> 2;
      return HTQ_HDR_WORDS + {dw[10:0], 1'b0}; // R1 R23
   endfunction

   // ==========================================================
   // Byte offered to the MAC next
   always_comb begin
      logic [HTQ_IDX_W-1:0] a;
      logic [15:0] w;
      logic [31:0] fcs;
      a = wrap_add(s_q.rd_base, HTQ_HDR_WORDS + {1'b0, s_q.idx[11:1]});
      w = s_q.mem[a];
      fcs = ~s_q.crc;
      next_byte = 8'h00;
      if (s_q.st == HTQ_FCS) begin
         next_byte = fcs[{s_q.idx[1:0], 3'b000} +: 8]; // R2
      end else if (s_q.idx < {1'b0, s_q.cnt}) begin
         next_byte = s_q.idx[0] ? w[15:8] : w[7:0]; // R11
      end
   end

   htq_crc_byte u_crc (
      .crc_in(s_q.crc),
      .data_in(next_byte),
      .crc_out(crc_next)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic wr_ev, rd_ev, enq, finish, data_acc;
      logic [HTQ_IDX_W-1:0] haddr, fw;
      logic [15:0] wd, ctl, cntw;
      logic [11:0] flen;
      logic [13:0] free_b, need_b;
      logic [15:0] irq_set;
      s_d = s_q;
      wr_ev = s_q.wr_s2 & ~s_q.wr_s3;
      rd_ev = s_q.rd_s2 & ~s_q.rd_s3;
      wd = s_q.wd_s2;
      enq = 1'b0;
      finish = 1'b0;
      irq_set = 16'h0000;
      fw = 12'h000;
      ctl = 16'h0000;
      cntw = 16'h0000;

      // Host strobes are asynchronous; every pin passes two flops
      s_d.wr_s1 = host_wr_in;
      s_d.wr_s2 = s_q.wr_s1;
      s_d.wr_s3 = s_q.wr_s2;
      s_d.rd_s1 = host_rd_in;
      s_d.rd_s2 = s_q.rd_s1;
      s_d.rd_s3 = s_q.rd_s2;
      s_d.big_s1 = host_big_endian_in;
      s_d.big_s2 = s_q.big_s1;
      s_d.addr_s1 = host_addr_in;
      s_d.addr_s2 = s_q.addr_s1;
      s_d.be_s1 = host_be_in;
      s_d.be_s2 = s_q.be_s1;
      s_d.wd_s1 = host_wdata_in;
      s_d.wd_s2 = s_q.wd_s1;

      // Free bytes: committed frames plus the frame being written
      free_b = {1'b0, HTQ_MEM_BYTES} - {s_q.used_words, 1'b0}
               - {3'b000, s_q.tx_data_pointer[10:0]}; // R14 R24
      need_b = {s_q.tx_space_needed[11:0], 2'b00}; // R18

      haddr = wrap_add(s_q.wr_base, {1'b0, s_q.tx_data_pointer[11:1]});
      data_acc = (s_q.addr_s2 == HTQ_OFS_TX_QUEUE_DATA)
                 && s_q.rx_queue_command[HTQ_RQC_ACCESS]; // R19

      // ==========================================================
      // Register writes
      if (wr_ev) begin
         unique case (s_q.addr_s2)
            HTQ_OFS_TX_CONTROL: begin
               s_d.tx_control = be_merge(s_q.tx_control, wd, s_q.be_s2); // R12 R13
            end
            HTQ_OFS_TX_QUEUE_COMMAND: begin
               if (s_q.be_s2[0] && wd[HTQ_TQC_ENQUEUE]
                   && !s_q.tx_queue_command[HTQ_TQC_ENQUEUE]) begin
                  enq = 1'b1; // R15
               end
               if (s_q.be_s2[0] && wd[HTQ_TQC_SPACE_REQ]) begin
                  s_d.tx_queue_command[HTQ_TQC_SPACE_REQ] = 1'b1; // R17
               end
            end
            HTQ_OFS_RX_QUEUE_COMMAND: begin
               s_d.rx_queue_command = be_merge(s_q.rx_queue_command, wd, s_q.be_s2);
            end
            HTQ_OFS_TX_DATA_POINTER: begin
               s_d.tx_data_pointer = be_merge(s_q.tx_data_pointer, wd, s_q.be_s2);
            end
            HTQ_OFS_INTERRUPT_ENABLE: begin
               s_d.interrupt_enable = be_merge(s_q.interrupt_enable, wd, s_q.be_s2);
            end
            HTQ_OFS_INTERRUPT_STATUS: begin
               // Write-one-to-clear; all ones empties the register
               s_d.interrupt_status = s_q.interrupt_status
                                      & ~be_merge(16'h0000, wd, s_q.be_s2); // R22
            end
            HTQ_OFS_TX_SPACE_NEEDED: begin
               s_d.tx_space_needed = be_merge(s_q.tx_space_needed, wd, s_q.be_s2);
            end
            HTQ_OFS_TX_QUEUE_DATA: begin
               if (data_acc) begin
                  s_d.mem[haddr] = be_merge(s_q.mem[haddr], wd, s_q.be_s2);
               end
            end
            default: begin
            end
         endcase
      end

      // ==========================================================
      // Register reads; unmapped offsets read zero
      if (rd_ev) begin
         unique case (s_q.addr_s2)
            HTQ_OFS_TX_CONTROL: s_d.rdata = s_q.tx_control;
            HTQ_OFS_TX_FRAME_STATUS: s_d.rdata = s_q.tx_frame_status; // R4
            HTQ_OFS_TX_FREE_MEMORY_INFO: s_d.rdata = {3'b000, free_b[12:0]}; // R14
            HTQ_OFS_TX_QUEUE_COMMAND: s_d.rdata = {14'h0000, s_q.tx_queue_command};
            HTQ_OFS_RX_QUEUE_COMMAND: s_d.rdata = s_q.rx_queue_command;
            HTQ_OFS_TX_DATA_POINTER: s_d.rdata = s_q.tx_data_pointer;
            HTQ_OFS_INTERRUPT_ENABLE: s_d.rdata = s_q.interrupt_enable;
            HTQ_OFS_INTERRUPT_STATUS: s_d.rdata = s_q.interrupt_status;
            HTQ_OFS_TX_SPACE_NEEDED: s_d.rdata = s_q.tx_space_needed;
            HTQ_OFS_TX_QUEUE_DATA: s_d.rdata = data_acc ? s_q.mem[haddr] : 16'h0000;
            default: s_d.rdata = 16'h0000;
         endcase
      end

      // Reads and writes of the data register both advance the pointer
      if ((wr_ev || rd_ev) && data_acc
          && s_q.tx_data_pointer[HTQ_PTR_AUTO_INC]) begin
         s_d.tx_data_pointer[10:0] = s_q.tx_data_pointer[10:0] + 11'h002; // R20
      end

      // ==========================================================
      // Manual enqueue commits the prepared frame
      if (enq) begin
         cntw = hdr_word(s_q.mem[wrap_add(s_q.wr_base, 12'h001)], s_q.big_s2);
         fw = frame_words(cntw[10:0]);
         s_d.wr_base = wrap_add(s_q.wr_base, fw); // R3
         s_d.used_words = s_q.used_words + {1'b0, fw}; // R24
         s_d.tx_queue_command[HTQ_TQC_ENQUEUE] = 1'b1; // R15
         s_d.tx_data_pointer[10:0] = 11'h000;
      end

      // ==========================================================
      // MAC drain
      if (s_q.mac_valid && mac_ready_in) begin
         s_d.mac_valid = 1'b0;
         s_d.mac_last = 1'b0;
         finish = s_q.mac_last;
      end
      flen = {1'b0, s_q.cnt};
      if (s_q.tx_control[HTQ_TXC_PAD] && flen < HTQ_MIN_FRAME) begin
         flen = HTQ_MIN_FRAME;
      end

      unique case (s_q.st)
         HTQ_IDLE: begin
            if (s_q.pending != '0 && s_q.tx_control[HTQ_TXC_ENABLE]) begin // R12
               ctl = hdr_word(s_q.mem[s_q.rd_base], s_q.big_s2); // R1 R5
               cntw = hdr_word(s_q.mem[wrap_add(s_q.rd_base, 12'h001)], s_q.big_s2);
               s_d.ctrl = ctl;
               s_d.cnt = cntw[10:0];
               s_d.idx = 12'h000;
               s_d.crc = HTQ_CRC_INIT;
               s_d.tx_frame_status = {7'h00, 1'b1, 2'b00, ctl[5:0]}; // R4 R9
               s_d.st = HTQ_DATA;
            end
         end
         HTQ_DATA: begin
            if (!finish && (!s_q.mac_valid || mac_ready_in) && s_q.idx < flen) begin
               s_d.mac_data = next_byte;
               s_d.mac_valid = 1'b1;
               s_d.crc = crc_next;
               s_d.idx = s_q.idx + 12'h001;
               s_d.mac_last = (s_q.idx == flen - 12'h001)
                              && !s_q.tx_control[HTQ_TXC_CRC];
               if (s_q.idx == flen - 12'h001 && s_q.tx_control[HTQ_TXC_CRC]) begin
                  s_d.st = HTQ_FCS; // R2
                  s_d.idx = 12'h000;
               end
            end
         end
         HTQ_FCS: begin
            if (!finish && (!s_q.mac_valid || mac_ready_in) && s_q.idx < 12'h004) begin
               s_d.mac_data = next_byte; // R2
               s_d.mac_valid = 1'b1;
               s_d.idx = s_q.idx + 12'h001;
               s_d.mac_last = (s_q.idx == 12'h003);
            end
         end
         default: s_d.st = HTQ_IDLE;
      endcase

      // ==========================================================
      // Frame fully handed to the MAC
      if (finish) begin
         fw = frame_words(s_q.cnt);
         s_d.st = HTQ_IDLE;
         s_d.rd_base = wrap_add(s_q.rd_base, fw);
         s_d.used_words = s_d.used_words - {1'b0, fw}; // R24
         s_d.tx_frame_status[HTQ_TFS_BUSY] = 1'b0;
         if (s_q.ctrl[HTQ_CW_IRQ_ON_COMPLETION]) begin
            irq_set[HTQ_IRQ_TX_DONE] = 1'b1; // R8
         end
         if (s_q.pending == 12'h001) begin
            s_d.tx_queue_command[HTQ_TQC_ENQUEUE] = 1'b0; // R15
         end
      end
      s_d.pending = s_q.pending + (enq ? 12'h001 : 12'h000) - (finish ? 12'h001 : 12'h000);

      // ==========================================================
      // Space request
      if (s_q.tx_queue_command[HTQ_TQC_SPACE_REQ] && free_b >= need_b) begin
         irq_set[HTQ_IRQ_TX_SPACE] = 1'b1; // R17
         s_d.tx_queue_command[HTQ_TQC_SPACE_REQ] = 1'b0;
      end

      // A set in the same cycle as a clear survives
      s_d.interrupt_status = s_d.interrupt_status | irq_set;
      s_d.irq = |(s_q.interrupt_status
                  & s_q.interrupt_enable
                  & ((16'h0001 << HTQ_IRQ_TX_DONE) | (16'h0001 << HTQ_IRQ_TX_SPACE))); // R21
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_q <= '0;
         s_q.tx_control <= HTQ_RST_TX_CONTROL;
         s_q.interrupt_enable <= HTQ_RST_REG;
         s_q.crc <= HTQ_CRC_INIT;
         s_q.st <= HTQ_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign host_rdata_out = s_q.rdata;
   assign host_irq_out = s_q.irq;
   assign mac_data_out = s_q.mac_data;
   assign mac_valid_out = s_q.mac_valid;
   assign mac_last_out = s_q.mac_last;
   assign mac_flow_ctrl_en_out = s_q.tx_control[HTQ_TXC_FLOW]; // R12
   assign mac_csum_en_out = s_q.tx_control[HTQ_TXC_CSUM_LO +: 4]; // R13
endmodule

// ### htq_tx_path_asserts.sv
// Concurrent checks on the ports of the host transmit queue
`timescale 1ns/1ns
module htq_tx_path_asserts (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic mac_ready_in,
   input wire logic [15:0] host_rdata_out,
   input wire logic host_irq_out,
   input wire logic [7:0] mac_data_out,
   input wire logic mac_valid_out,
   input wire logic mac_last_out,
   input wire logic mac_flow_ctrl_en_out,
   input wire logic [3:0] mac_csum_en_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   // ==========================================================
   // Cycles since the last strobe or frame end, saturating
   logic [3:0] wr_age_q;
   logic [3:0] rd_age_q;
   logic [3:0] end_age_q;
   always_ff @(posedge clk_in) begin
      wr_age_q <= host_wr_in ? 4'h0 : (reset_in || &wr_age_q) ? 4'hf : wr_age_q + 4'h1;
      rd_age_q <= host_rd_in ? 4'h0 : (reset_in || &rd_age_q) ? 4'hf : rd_age_q + 4'h1;
      end_age_q <= (mac_valid_out && mac_ready_in && mac_last_out) ? 4'h0 :
         (reset_in || &end_age_q) ? 4'hf : end_age_q + 4'h1;
   end

   // ==========================================================
   // Byte stream
   sequence stall_s;
      mac_valid_out && !mac_ready_in;
   endsequence
   sequence acc_last_s;
      mac_valid_out && mac_ready_in && mac_last_out;
   endsequence

   hold_until_taken_a: assert property (stall_s |=> mac_valid_out &&
      $stable(mac_data_out) && $stable(mac_last_out)) else $error("byte dropped while stalled");
   gap_after_frame_a: assert property (acc_last_s |=> !mac_valid_out)
      else $error("no idle cycle after frame");
   last_with_valid_a: assert property (mac_last_out |-> mac_valid_out)
      else $error("last flag without valid");

   // ==========================================================
   // Register side effects; strobes pass a synchroniser first
   flow_needs_write_a: assert property ($changed(mac_flow_ctrl_en_out) |-> wr_age_q <= 4'h6)
      else $error("flow enable moved without a write");
   csum_needs_write_a: assert property ($changed(mac_csum_en_out) |-> wr_age_q <= 4'h6)
      else $error("checksum enables moved without a write");
   irq_rise_cause_a: assert property ($rose(host_irq_out) |->
      wr_age_q <= 4'h8 || end_age_q <= 4'h8) else $error("interrupt rose without cause");
   irq_fall_cause_a: assert property ($fell(host_irq_out) |-> wr_age_q <= 4'h8)
      else $error("interrupt fell without a write");
   rdata_stands_a: assert property ($changed(host_rdata_out) |-> rd_age_q <= 4'h3)
      else $error("read data moved without a read");
endmodule

bind htq_tx_path htq_tx_path_asserts htq_tx_path_asserts_inst (
   .clk_in(clk_in), .reset_in(reset_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
   .mac_ready_in(mac_ready_in), .host_rdata_out(host_rdata_out), .host_irq_out(host_irq_out),
   .mac_data_out(mac_data_out), .mac_valid_out(mac_valid_out), .mac_last_out(mac_last_out),
   .mac_flow_ctrl_en_out(mac_flow_ctrl_en_out), .mac_csum_en_out(mac_csum_en_out)
);

// ### testbench.sv
// Self-checking bench for the host transmit queue frame path
`timescale 1ns/1ns
module testbench;
   import htq_pkg::*;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic big = 1'b0;
   logic [1:0] be = 2'b11;
   logic stall = 1'b1;
   logic [8:0] addr = 9'h000;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] got;
   logic [15:0] rdata;
   logic [15:0] txc;
   logic ready, irq, valid, last, flow;
   logic [7:0] mdata;
   logic [3:0] csum;
   logic [31:0] seed = 32'hc9995a57;
   logic [15:0] exp_q[$];
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;

   always #25 clk_in = ~clk_in;

   htq_tx_path htq_tx_path_inst (
      .clk_in(clk_in), .reset_in(reset_in), .host_addr_in(addr), .host_wr_in(host_wr),
      .host_rd_in(host_rd), .host_be_in(be), .host_wdata_in(wdata),
      .host_big_endian_in(big), .mac_ready_in(ready), .host_rdata_out(rdata),
      .host_irq_out(irq), .mac_data_out(mdata), .mac_valid_out(valid), .mac_last_out(last),
      .mac_flow_ctrl_en_out(flow), .mac_csum_en_out(csum)
   );
   htq_mac_sink htq_mac_sink_inst (.clk_in(clk_in), .stall_en_in(stall), .mac_ready_out(ready));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ 32'hedb88320 : r >> 1;
      return r;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Address and data settle a cycle ahead of the strobe
   task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d);
      @(negedge clk_in);
      addr = a;
      wdata = d;
      @(negedge clk_in);
      host_wr = w;
      host_rd = !w;
      repeat (4) @(negedge clk_in);
      host_wr = 1'b0;
      host_rd = 1'b0;
      repeat (5) @(negedge clk_in);
      got = rdata;
   endtask
   task automatic put(input logic [8:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic get(input logic [8:0] a);
      bus(1'b0, a, 16'h0000);
   endtask

   // ==========================================================
   // One frame: prepare, enqueue, drain, then status and interrupt
   task automatic send_frame(input logic [5:0] id, input int len, input logic ic);
      logic [7:0] b[$];
      logic [7:0] e[$];
      logic [31:0] c;
      logic [15:0] cw;
      logic [15:0] bc;
      c = 32'hffffffff;
      cw = {ic, 9'h000, id};
      bc = 16'(len);
      for (int k = 0; k < len; k++) begin
         seed = lfsr(seed);
         b.push_back(seed[7:0]);
      end
      e = b;
      while (txc[HTQ_TXC_PAD] && e.size() < 60) e.push_back(8'h00);
      foreach (e[k]) c = crc_step(c, e[k]);
      if (txc[HTQ_TXC_CRC]) for (int k = 0; k < 4; k++) e.push_back(~c[8*k +: 8]);
      foreach (e[k]) exp_q.push_back({7'h00, k == e.size() - 1, e[k]});
      while (b.size() % 4 != 0) b.push_back(8'h00);
      put(HTQ_OFS_TX_DATA_POINTER, 16'h4000);
      put(HTQ_OFS_TX_QUEUE_DATA, big ? {cw[7:0], cw[15:8]} : cw);
      put(HTQ_OFS_TX_QUEUE_DATA, big ? {bc[7:0], bc[15:8]} : bc);
      for (int k = 0; k < b.size(); k += 2) put(HTQ_OFS_TX_QUEUE_DATA, {b[k+1], b[k]});
      get(HTQ_OFS_TX_DATA_POINTER);
      chk(got, 16'h4000 | 16'(4 + b.size()));
      get(HTQ_OFS_TX_FREE_MEMORY_INFO);
      chk(got, 16'(6144 - 4 - b.size()));
      put(HTQ_OFS_TX_QUEUE_COMMAND, 16'h0001);
      get(HTQ_OFS_TX_FRAME_STATUS);
      chk(got & 16'h013f, {7'h00, 1'b1, 2'b00, id});
      get(HTQ_OFS_TX_QUEUE_COMMAND);
      for (int t = 0; t < 300 && got[HTQ_TQC_ENQUEUE] !== 1'b0; t++) begin
         get(HTQ_OFS_TX_QUEUE_COMMAND);
      end
      chk(got & 16'h0001, 16'h0000);
      chk(16'(exp_q.size()), 16'h0000);
      get(HTQ_OFS_TX_FREE_MEMORY_INFO);
      chk(got, 16'h1800);
      get(HTQ_OFS_INTERRUPT_STATUS);
      chk(got & 16'h4000, {1'b0, ic, 14'h0000});
      chk({15'h0000, irq}, {15'h0000, ic});
      put(HTQ_OFS_INTERRUPT_STATUS, HTQ_CLEAR_ALL);
      get(HTQ_OFS_INTERRUPT_STATUS);
      chk({got[14:0], irq}, 16'h0000);
   endtask

   // Oldest expected byte is compared whenever the MAC takes one
   always @(posedge clk_in) begin
      if (!reset_in && valid && ready) begin
         if (exp_q.size() == 0) chk(16'hdead, 16'h0000);
         else chk({7'h00, last, mdata}, exp_q.pop_front());
      end
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         report_and_stop();
      end
   end

   initial begin
      repeat (5) @(negedge clk_in);
      reset_in = 1'b0;
      get(HTQ_OFS_TX_CONTROL);
      chk(got, HTQ_RST_TX_CONTROL);
      put(HTQ_OFS_TX_FREE_MEMORY_INFO, 16'h0000);
      get(HTQ_OFS_TX_FREE_MEMORY_INFO);
      chk(got, 16'h1800);
      get(9'h1a0);
      chk(got, 16'h0000);
      put(HTQ_OFS_TX_DATA_POINTER, 16'h4000);
      put(HTQ_OFS_TX_QUEUE_DATA, 16'h1234);
      get(HTQ_OFS_TX_DATA_POINTER);
      chk(got, 16'h4000);
      $display("test reset_and_access done");
      put(HTQ_OFS_RX_QUEUE_COMMAND, 16'h0008);
      put(HTQ_OFS_INTERRUPT_ENABLE, 16'h4040);
      txc = 16'h01e9;
      put(HTQ_OFS_TX_CONTROL, txc);
      chk({11'h000, csum, flow}, {11'h000, txc[8:5], txc[3]});
      send_frame(6'h2a, 61 + int'(seed[5:0]), 1'b1);
      $display("test stalled_frame done");
      txc = 16'h0007;
      put(HTQ_OFS_TX_CONTROL, txc);
      chk({11'h000, csum, flow}, 16'h0000);
      big = 1'b1;
      stall = 1'b0;
      send_frame(6'h15, 20, 1'b0);
      $display("test padded_crc_frame done");
      put(HTQ_OFS_INTERRUPT_ENABLE, 16'h4000);
      put(HTQ_OFS_TX_SPACE_NEEDED, 16'h0004);
      put(HTQ_OFS_TX_QUEUE_COMMAND, 16'h0002);
      get(HTQ_OFS_INTERRUPT_STATUS);
      chk({14'h0000, got[6], irq}, 16'h0002);
      put(HTQ_OFS_INTERRUPT_ENABLE, 16'h4040);
      chk({15'h0000, irq}, 16'h0001);
      put(HTQ_OFS_INTERRUPT_STATUS, HTQ_CLEAR_ALL);
      chk({15'h0000, irq}, 16'h0000);
      put(HTQ_OFS_TX_SPACE_NEEDED, 16'h0800);
      put(HTQ_OFS_TX_QUEUE_COMMAND, 16'h0002);
      get(HTQ_OFS_TX_QUEUE_COMMAND);
      chk(got & 16'h0002, 16'h0002);
      get(HTQ_OFS_INTERRUPT_STATUS);
      chk(got & 16'h0040, 16'h0000);
      // Low byte only: upper byte of the request must survive
      be = 2'b01;
      put(HTQ_OFS_TX_SPACE_NEEDED, 16'hffff);
      be = 2'b11;
      get(HTQ_OFS_TX_SPACE_NEEDED);
      chk(got, 16'h08ff);
      $display("test space_request done");
      report_and_stop();
   end
endmodule
